/* File: pkg/vsp_pkg.sv */
// Function
// - horizontal sync ends at a 10-bit pixel position, reset value 040h.
// - new horizontal sync end applies only when its upper byte is written.
// - written positions survive standard changes; reset restores defaults.
// - vertical sync starts on a 10-bit line; default 004h (525) or 001h (625).
// - vertical sync ends on a 10-bit line; default 007h (525) or 004h (625).
// - vertical blank begins on a 10-bit line; default 001h (525), 26Fh (625).
// - vertical blank ends on a 10-bit line; default 015h (525), 017h (625).
// - signed 8-bit line shift moves both embedded field and vertical flags.
// - second signed 8-bit shift moves field flag relative to vertical flag.
// - both embedded flag shifts act only on standard line counts.
// - horizontal sync starts at a 10-bit pixel position, default zero.
package vsp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // subaddresses of the position register pairs, low byte first
    localparam int          NUM_POS = 6;
    localparam logic [7:0]  POS_LO_ADDR [NUM_POS] = '{
        8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24};
    localparam logic [7:0]  ADDR_FLAG_SHIFT  = 8'h26;
    localparam logic [7:0]  ADDR_FIELD_SHIFT = 8'h27;

    // index of each position inside the arrays
    localparam int          POS_HS_START = 0;
    localparam int          POS_HS_END   = 1;
    localparam int          POS_VS_FIRST = 2;
    localparam int          POS_VS_LAST  = 3;
    localparam int          POS_BL_FIRST = 4;
    localparam int          POS_BL_LAST  = 5;

    // defaults for 525-line and 625-line video
    localparam logic [9:0]  POS_DEF_525 [NUM_POS] = '{
        10'h000, 10'h040, 10'h004, 10'h007, 10'h001, 10'h015};
    localparam logic [9:0]  POS_DEF_625 [NUM_POS] = '{
        10'h000, 10'h040, 10'h001, 10'h004, 10'h26F, 10'h017};
    localparam logic [7:0]  SHIFT_RST = 8'h00;

    // field layout of a position pair
    localparam int          POS_W    = 10;
    localparam int          HI_BITS  = 2;

    ////////////////////////////////////////////////////////////////////////
    // frame lengths and standard embedded flag windows [first, last)
    localparam logic [9:0]  LINES_525     = 10'h20D;
    localparam logic [9:0]  LINES_625     = 10'h271;
    localparam logic [9:0]  V1_525_FIRST  = 10'h001;
    localparam logic [9:0]  V1_525_LAST   = 10'h014;
    localparam logic [9:0]  V2_525_FIRST  = 10'h108;
    localparam logic [9:0]  V2_525_LAST   = 10'h11B;
    localparam logic [9:0]  F0_525_FIRST  = 10'h004;
    localparam logic [9:0]  F0_525_LAST   = 10'h10A;
    localparam logic [9:0]  V1_625_FIRST  = 10'h270;
    localparam logic [9:0]  V1_625_LAST   = 10'h017;
    localparam logic [9:0]  V2_625_FIRST  = 10'h137;
    localparam logic [9:0]  V2_625_LAST   = 10'h150;
    localparam logic [9:0]  F1_625_FIRST  = 10'h139;
    localparam logic [9:0]  F1_625_LAST   = 10'h272;
    localparam logic [9:0]  FIRST_LINE    = 10'h001;
    localparam logic [9:0]  CNT_MAX       = 10'h3FF;

endpackage

/* File: rtl/vsp_pos_reg.sv */
`timescale 1ns/10ps
// one 10-bit position held as a low/high subaddress pair
module vsp_pos_reg #(
    parameter logic [9:0] DEF_525 = 10'h000,
    parameter logic [9:0] DEF_625 = 10'h000
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // write strobes and data
    input  wire logic       lo_wr,
    input  wire logic       hi_wr,
    input  wire logic [7:0] wdata,
    // current standard
    input  wire logic       std_625,
    // position in force
    output logic      [9:0] pos
);

    logic [7:0] shadow_q;
    logic [9:0] val_q;
    logic       set_q;

    // low byte only lands in the shadow, so comparators never see half
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shadow_q <= 8'h00;
        end else if (lo_wr) begin
            shadow_q <= wdata;
        end
    end

    // commit on the upper byte; set flag pins the value until reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            val_q <= 10'h000;
            set_q <= 1'b0;
        end else if (hi_wr) begin
            val_q <= {wdata[vsp_pkg::HI_BITS-1:0], shadow_q};
            set_q <= 1'b1;
        end
    end

    // untouched positions follow the standard, touched ones do not
    assign pos = set_q ? val_q : (std_625 ? DEF_625 : DEF_525);

    AST_HI_COMMIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hi_wr |=> pos == {$past(wdata[1:0]), $past(shadow_q)})
        else $error("upper byte write did not commit both bytes");

    AST_LO_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        lo_wr && !hi_wr |=> $stable(val_q) && $stable(set_q))
        else $error("lower byte write changed the active position");

    // a commit in the previous cycle legitimately moves pos, so skip it
    AST_KEEP_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(set_q) && !$past(hi_wr) && $changed(std_625)
        |-> $stable(pos))
        else $error("programmed position moved on a standard change");

    AST_DEFAULT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !set_q |-> pos == (std_625 ? DEF_625 : DEF_525))
        else $error("unprogrammed position is not the standard default");

endmodule

/* File: rtl/vsp_sync_timing.sv */
`timescale 1ns/10ps
// programmable sync positions and embedded flag placement
module vsp_sync_timing (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // subaddressed register port
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_subaddr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // line-locked reference from the decoder core
    input  wire logic       std_625,
    input  wire logic       lines_std,
    input  wire logic       line_tick,
    input  wire logic       frame_tick,
    // sync timing to the video processor
    output logic            hsync_out,
    output logic            vsync_out,
    output logic            vertical_blank_window,
    output logic            emb_v_flag,
    output logic            emb_f_flag
);

    ////////////////////////////////////////////////////////////////////////
    // wrap-aware window test, [first, last)
    function automatic logic in_win(input logic [9:0] p,
                                    input logic [9:0] first,
                                    input logic [9:0] last);
        in_win = (first <= last) ? (p >= first && p < last)
                                 : (p >= first || p < last);
    endfunction

    // line moved back by a signed offset, folded into 1..frame length
    function automatic logic [9:0] shift_line(input logic [9:0] line,
                                              input logic signed [8:0] off,
                                              input logic [9:0] tot);
        logic signed [11:0] t;
        t = $signed({2'b00, line}) - 12'(off);
        if (t < 12'sd1) begin
            t = t + $signed({2'b00, tot});
        end else if (t > $signed({2'b00, tot})) begin
            t = t - $signed({2'b00, tot});
        end
        shift_line = t[9:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // position register pairs
    logic [9:0] pos     [vsp_pkg::NUM_POS];
    logic [7:0] rd_part [vsp_pkg::NUM_POS];

    genvar gi;
    generate
        for (gi = 0; gi < vsp_pkg::NUM_POS; gi++) begin : g_pos
            wire logic [7:0] lo_addr = vsp_pkg::POS_LO_ADDR[gi];
            wire logic       hit_lo  = (reg_subaddr == lo_addr);
            wire logic       hit_hi  = (reg_subaddr == 8'(lo_addr + 8'h01));

            vsp_pos_reg #(
                .DEF_525 (vsp_pkg::POS_DEF_525[gi]),
                .DEF_625 (vsp_pkg::POS_DEF_625[gi])
            ) u_pos (
                .ref_clk (ref_clk),
                .sys_rst (sys_rst),
                .lo_wr   (reg_wr_en && hit_lo),
                .hi_wr   (reg_wr_en && hit_hi),
                .wdata   (reg_wdata),
                .std_625 (std_625),
                .pos     (pos[gi])
            );

            // reserved upper bits read as zero
            assign rd_part[gi] = hit_lo ? pos[gi][7:0]
                               : hit_hi ? {6'h00, pos[gi][9:8]}
                               : 8'h00;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // embedded flag shifts, single-byte registers
    logic [7:0] flag_shift_q;
    logic [7:0] field_shift_q;

    wire logic hit_flag  = (reg_subaddr == vsp_pkg::ADDR_FLAG_SHIFT);
    wire logic hit_field = (reg_subaddr == vsp_pkg::ADDR_FIELD_SHIFT);

    // only reset or a write of 00h brings these back to zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_shift_q  <= vsp_pkg::SHIFT_RST;
            field_shift_q <= vsp_pkg::SHIFT_RST;
        end else if (reg_wr_en && hit_flag) begin
            flag_shift_q  <= reg_wdata;
        end else if (reg_wr_en && hit_field) begin
            field_shift_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback, one cycle after the read strobe; unmapped reads give zero
    logic [7:0] rd_pos;
    always_comb begin
        rd_pos = 8'h00;
        for (int i = 0; i < vsp_pkg::NUM_POS; i++) begin
            rd_pos = rd_pos | rd_part[i];
        end
    end

    wire logic [7:0] rd_mux = hit_flag  ? flag_shift_q
                            : hit_field ? field_shift_q
                            : rd_pos;

    logic [7:0] rdata_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // pixel and line counters; pixel 0 follows the line tick
    logic [9:0] pix_q;
    logic [9:0] line_q;

    wire logic [9:0] pix_d  = line_tick ? 10'h000
                            : (pix_q == vsp_pkg::CNT_MAX) ? pix_q
                            : 10'(pix_q + 10'h001);
    wire logic [9:0] line_d = (line_tick && frame_tick) ? vsp_pkg::FIRST_LINE
                            : (line_tick && line_q != vsp_pkg::CNT_MAX)
                              ? 10'(line_q + 10'h001)
                            : line_q;

    // counters saturate so a lost tick cannot wrap into a false sync
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pix_q  <= 10'h000;
            line_q <= vsp_pkg::FIRST_LINE;
        end else begin
            pix_q  <= pix_d;
            line_q <= line_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync and blank windows from the positions in force
    wire logic hs_d = in_win(pix_q, pos[vsp_pkg::POS_HS_START],
                             pos[vsp_pkg::POS_HS_END]);
    wire logic vs_d = in_win(line_q, pos[vsp_pkg::POS_VS_FIRST],
                             pos[vsp_pkg::POS_VS_LAST]);
    wire logic bl_d = in_win(line_q, pos[vsp_pkg::POS_BL_FIRST],
                             pos[vsp_pkg::POS_BL_LAST]);

    ////////////////////////////////////////////////////////////////////////
    // embedded flags: shifts ignored on nonstandard line counts
    wire logic [9:0]        tot     = std_625 ? vsp_pkg::LINES_625
                                              : vsp_pkg::LINES_525;
    wire logic signed [8:0] v_off   = lines_std
                                      ? 9'($signed(flag_shift_q))
                                      : 9'sd0;
    wire logic signed [8:0] f_off   = lines_std
                                      ? 9'($signed(flag_shift_q))
                                        + 9'($signed(field_shift_q))
                                      : 9'sd0;
    wire logic [9:0]        v_fold  = shift_line(line_q, v_off, tot);
    wire logic [9:0]        f_fold  = shift_line(line_q, f_off, tot);
    // no fold on nonstandard frames: a line past the nominal length
    // must not be wrapped onto the standard flag windows
    wire logic [9:0]        v_line  = lines_std ? v_fold : line_q;
    wire logic [9:0]        f_line  = lines_std ? f_fold : line_q;

    wire logic ev_525 = in_win(v_line, vsp_pkg::V1_525_FIRST,
                               vsp_pkg::V1_525_LAST)
                     || in_win(v_line, vsp_pkg::V2_525_FIRST,
                               vsp_pkg::V2_525_LAST);
    wire logic ev_625 = in_win(v_line, vsp_pkg::V1_625_FIRST,
                               vsp_pkg::V1_625_LAST)
                     || in_win(v_line, vsp_pkg::V2_625_FIRST,
                               vsp_pkg::V2_625_LAST);
    wire logic ef_525 = !in_win(f_line, vsp_pkg::F0_525_FIRST,
                                vsp_pkg::F0_525_LAST);
    wire logic ef_625 = in_win(f_line, vsp_pkg::F1_625_FIRST,
                               vsp_pkg::F1_625_LAST);
    wire logic ev_d   = std_625 ? ev_625 : ev_525;
    wire logic ef_d   = std_625 ? ef_625 : ef_525;

    ////////////////////////////////////////////////////////////////////////
    // output flops, one cycle behind the counters
    logic hs_q;
    logic vs_q;
    logic bl_q;
    logic ev_q;
    logic ef_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            bl_q <= 1'b0;
            ev_q <= 1'b0;
            ef_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
            vs_q <= vs_d;
            bl_q <= bl_d;
            ev_q <= ev_d;
            ef_q <= ef_d;
        end
    end

    assign hsync_out             = hs_q;
    assign vsync_out             = vs_q;
    assign vertical_blank_window = bl_q;
    assign emb_v_flag            = ev_q;
    assign emb_f_flag            = ef_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_hs_end_cross;
        pix_q == pos[vsp_pkg::POS_HS_END]
            && pos[vsp_pkg::POS_HS_START] < pos[vsp_pkg::POS_HS_END];
    endsequence

    AST_HS_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hs_end_cross |=> !hsync_out)
        else $error("horizontal sync still high at its end pixel");

    AST_HS_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pix_q == pos[vsp_pkg::POS_HS_START]
            && pos[vsp_pkg::POS_HS_START] != pos[vsp_pkg::POS_HS_END]
        |=> hsync_out)
        else $error("horizontal sync not high at its start pixel");

    AST_HS_RESET_END: assert property (@(posedge ref_clk)
        sys_rst ##1 !sys_rst |-> pos[vsp_pkg::POS_HS_END] == 10'h040)
        else $error("horizontal sync end not at reset value");

    sequence s_hs_lo_then_hi;
        reg_wr_en
            && reg_subaddr == vsp_pkg::POS_LO_ADDR[vsp_pkg::POS_HS_START]
        ##1 !reg_wr_en
        ##1 reg_wr_en && reg_subaddr
            == 8'(vsp_pkg::POS_LO_ADDR[vsp_pkg::POS_HS_START] + 8'h01);
    endsequence

    // low byte, one idle cycle, high byte: the committed low byte is the
    // one written three cycles back, not the data of the upper write
    AST_HS_PAIR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_hs_lo_then_hi |=> pos[vsp_pkg::POS_HS_START][7:0]
                             == $past(reg_wdata, 3))
        else $error("pair write did not land low byte");

    AST_VS_WIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        line_q == pos[vsp_pkg::POS_VS_FIRST]
            && pos[vsp_pkg::POS_VS_FIRST] != pos[vsp_pkg::POS_VS_LAST]
        |=> vsync_out)
        else $error("vertical sync missing on its first line");

    AST_VS_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
        line_q == pos[vsp_pkg::POS_VS_LAST] |=> !vsync_out)
        else $error("vertical sync still high on its last line");

    AST_BL_WIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        line_q == pos[vsp_pkg::POS_BL_LAST] |=> !vertical_blank_window)
        else $error("vertical blank still high after its end line");

    AST_BL_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
        line_q == pos[vsp_pkg::POS_BL_FIRST]
            && pos[vsp_pkg::POS_BL_FIRST] != pos[vsp_pkg::POS_BL_LAST]
        |=> vertical_blank_window)
        else $error("vertical blank missing on its first line");

    AST_NONSTD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !lines_std |-> v_line == line_q && f_line == line_q)
        else $error("flag shift applied to nonstandard video");

    AST_V_SHIFT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        lines_std && field_shift_q == 8'h00 |-> v_line == f_line)
        else $error("field flag moved with zero relative shift");

    AST_ZERO_SHIFT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        flag_shift_q == 8'h00 && field_shift_q == 8'h00
            && line_q != 10'h000 && line_q <= tot
        |-> v_line == line_q)
        else $error("zero shift moved the embedded flags");

endmodule

/* File: test/vsp_video_sink.sv */
`timescale 1ns/10ps
// downstream processor model: measures each horizontal sync pulse
module vsp_video_sink (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // sync timing from the decoder
    input  wire logic       hsync_out,
    // measured width in pixels, valid for one cycle
    output logic      [9:0] hs_width,
    output logic            hs_done
);
    logic [9:0] cnt_q;

    ////////////////////////////////////////////////////////////////////
    // count pixels while sync is high, report at the falling edge;
    // a pulse that never falls is never reported, so a stuck sync
    // shows up as a missing result
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q    <= 10'h000;
            hs_width <= 10'h000;
            hs_done  <= 1'b0;
        end else begin
            hs_done  <= !hsync_out && (cnt_q != 10'h000);
            hs_width <= cnt_q;
            cnt_q    <= hsync_out ? cnt_q + 10'h001 : 10'h000;
        end
    end
endmodule

/* File: test/test_vsp_sync_timing.sv */
`timescale 1ns/10ps
module test_vsp_sync_timing;
    typedef struct packed {
        logic [7:0] o1;
        logic [7:0] o2;
        logic       std;
        logic [9:0] line;
        logic [3:0] exp;
    } vsp_flag_case_t;
    // exp is {vsync, blank, v flag, f flag}
    localparam vsp_flag_case_t CASES [13] = '{
        '{8'h00, 8'h00, 1'b1, 10'h003, 4'h7},
        '{8'h00, 8'h00, 1'b1, 10'h006, 4'hE},
        '{8'h00, 8'h00, 1'b1, 10'h007, 4'h6},
        '{8'h00, 8'h00, 1'b1, 10'h013, 4'h6},
        '{8'h00, 8'h00, 1'b1, 10'h014, 4'h4},
        '{8'h00, 8'h00, 1'b1, 10'h015, 4'h0},
        '{8'h05, 8'h00, 1'b1, 10'h018, 4'h2},
        '{8'h05, 8'h00, 1'b1, 10'h019, 4'h0},
        '{8'h05, 8'hFD, 1'b1, 10'h005, 4'hD},
        '{8'h05, 8'h00, 1'b0, 10'h014, 4'h4},
        '{8'h7F, 8'h00, 1'b1, 10'h092, 4'h2},
        '{8'h7F, 8'h00, 1'b1, 10'h093, 4'h0},
        '{8'h80, 8'h00, 1'b1, 10'h094, 4'h3}};
    // reset readback of 1Ah..27h for 525-line video
    localparam logic [7:0] DEF_TBL [14] = '{8'h00, 8'h00, 8'h40, 8'h00,
        8'h04, 8'h00, 8'h07, 8'h00, 8'h01, 8'h00, 8'h15, 8'h00, 8'h00,
        8'h00};
    localparam int LINE = 200;

    logic       ref_clk;
    logic       sys_rst;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_subaddr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       std_625;
    logic       lines_std;
    logic       line_tick;
    logic       frame_tick;
    logic       hsync_out;
    logic       vsync_out;
    logic       vertical_blank_window;
    logic       emb_v_flag;
    logic       emb_f_flag;
    logic [9:0] hs_width;
    logic       hs_done;
    logic       rd_d1;
    logic       rd_d2;
    logic       meas_en;
    logic       snap;
    logic [31:0] seed;
    logic [7:0] e;
    logic [9:0] exp_q [$];
    int         num_errors;
    int         samples_checked;

    vsp_sync_timing u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_subaddr(reg_subaddr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .std_625(std_625),
        .lines_std(lines_std), .line_tick(line_tick),
        .frame_tick(frame_tick), .hsync_out(hsync_out),
        .vsync_out(vsync_out),
        .vertical_blank_window(vertical_blank_window),
        .emb_v_flag(emb_v_flag), .emb_f_flag(emb_f_flag));

    vsp_video_sink u_sink (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsync_out(hsync_out),
        .hs_width(hs_width), .hs_done(hs_done));

    ////////////////////////////////////////////////////////////////////
    // clock, verdict and hang guard
    always #20 ref_clk = ~ref_clk;

    task automatic end_sim();
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(30000 * 40);
        $display("Error %0t: watchdog expired", $time);
        num_errors = num_errors + 1;
        end_sim();
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // result monitor: read answers, sink widths and flag snapshots
    always @(posedge ref_clk) begin
        rd_d1 <= reg_rd_en;
        rd_d2 <= rd_d1;
    end

    task automatic check(input logic [9:0] got);
        logic [9:0] ex;
        if (exp_q.size() == 0) begin
            $display("Error %0t: unexpected result %h", $time, got);
            num_errors = num_errors + 1;
        end else begin
            ex = exp_q.pop_front();
            samples_checked = samples_checked + 1;
            if (got !== ex) begin
                $display("Error %0t: got %h want %h", $time, got, ex);
                num_errors = num_errors + 1;
            end
        end
    endtask

    // sampled mid-cycle so every registered output has settled
    always @(negedge ref_clk) begin
        if (rd_d2 === 1'b1)
            check({2'b00, reg_rdata});
        if (hs_done === 1'b1 && meas_en)
            check(hs_width);
        if (snap)
            check({6'h00, vsync_out, vertical_blank_window, emb_v_flag,
                   emb_f_flag});
    end

    ////////////////////////////////////////////////////////////////////
    // host and line-reference drivers, all launched 1 ns after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_wr_en = 1'b1;
        reg_subaddr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1 reg_wr_en = 1'b0;
    endtask

    // spaced reads so the answer is looked at while it still stands
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back({2'b00, d});
        @(posedge ref_clk);
        #1 reg_rd_en = 1'b1;
        reg_subaddr = a;
        @(posedge ref_clk);
        #1 reg_rd_en = 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic run_lines(input int n, input logic [9:0] w);
        meas_en = 1'b1;
        repeat (n) begin
            exp_q.push_back(w);
            @(posedge ref_clk);
            #1 line_tick = 1'b1;
            @(posedge ref_clk);
            #1 line_tick = 1'b0;
            repeat (LINE - 2) @(posedge ref_clk);
        end
        meas_en = 1'b0;
    endtask

    // steps the line counter straight to the wanted line, then looks
    task automatic goto_line(input logic [9:0] ln, input logic [3:0] x);
        @(posedge ref_clk);
        #1 line_tick = 1'b1;
        frame_tick = 1'b1;
        @(posedge ref_clk);
        #1 frame_tick = 1'b0;
        repeat (ln - 10'h001) @(posedge ref_clk);
        #1 line_tick = 1'b0;
        repeat (2) @(posedge ref_clk);
        exp_q.push_back({6'h00, x});
        #1 snap = 1'b1;
        @(posedge ref_clk);
        #1 snap = 1'b0;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        #1 sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        {reg_wr_en, reg_rd_en, line_tick, frame_tick} = 4'h0;
        reg_subaddr = 8'h00;
        reg_wdata = 8'h00;
        {std_625, lines_std, meas_en, snap} = 4'h4;
        {rd_d1, rd_d2} = 2'b00;
        seed = 32'h0001_3EF6;
        num_errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        for (int i = 0; i < 14; i++)
            rd(8'h1A + i[7:0], DEF_TBL[i]);
        rd(8'h28, 8'h00);
        // the pulse launched by reset would merge into the first line
        repeat (64) @(posedge ref_clk);
        run_lines(2, 10'h040);
        // lower byte alone must stay in the shadow
        e = 8'h10 + {1'b0, 7'(xs())};
        wr(8'h1C, e);
        rd(8'h1C, 8'h40);
        run_lines(1, 10'h040);
        wr(8'h1D, 8'h00);
        rd(8'h1C, e);
        run_lines(2, {2'b00, e});
        wr(8'h1A, 8'h05);
        wr(8'h1B, 8'h00);
        run_lines(1, {2'b00, e} - 10'h005);
        // written value pinned across a standard change
        wr(8'h1E, 8'h09);
        wr(8'h1F, 8'hFD);
        std_625 = 1'b1;
        rd(8'h1E, 8'h09);
        rd(8'h1F, 8'h01);
        rd(8'h1C, e);
        rd(8'h20, 8'h04);
        rd(8'h22, 8'h6F);
        rd(8'h23, 8'h02);
        rd(8'h24, 8'h17);
        do_reset();
        rd(8'h1E, 8'h01);
        rd(8'h1C, 8'h40);
        #1 std_625 = 1'b0;
        do_reset();
        // embedded flag placement, shifts and nonstandard line counts
        foreach (CASES[i]) begin
            wr(8'h26, CASES[i].o1);
            wr(8'h27, CASES[i].o2);
            lines_std = CASES[i].std;
            goto_line(CASES[i].line, CASES[i].exp);
        end
        rd(8'h26, 8'h80);
        // 625-line flag windows with the shifts cleared
        wr(8'h26, 8'h00);
        std_625 = 1'b1;
        goto_line(10'h002, 4'hE);
        goto_line(10'h139, 4'h3);
        repeat (4) @(posedge ref_clk);
        if (exp_q.size() != 0) begin
            $display("Error %0t: results missing", $time);
            num_errors = num_errors + 1;
        end
        end_sim();
    end
endmodule
